// file: logic/motor_pwm_output_stage.sv
// Purpose: Output stage of a motor PWM unit: duty compare, dead time, fault and manual override.
// Assumes: Time base count and period-start pulse come from a neighbouring time base, synchronous to pclk.
// Notes: NUM_PAIRS = 1 builds the single-pair second instance.
`timescale 1ns/10ps

// ==========================================================
// Notes on behaviour
// - Per pair, active-edge select picks dead unit B (1) or A (0) for high going active.
// - Per pair, inactive-edge select picks unit B (1) or A (0) for low going active.
// - On a fault, controlled pins take their override value, 1 active, bits 13..8.
// - Fault mode bit 7: 1 cycle by cycle, 0 latched override.
// - Per-pin generator-control bit: 1 generator drives, 0 manual bit; resets to 1.
// - Three 16-bit read/write duty registers, reset to zero.
// - Second instance implements only one pair; other pair controls absent.
// - Unimplemented bits ignore writes and read zero, except the independent-mode bits and the duty registers of absent pairs.
// - Two dead units delay by a 6-bit count of pclk divided by 1, 2, 4 or 8.
// - Immediate update applies duty writes at once, else at period start.
// - In complementary mode low is the complement of high, apart from dead time.
// - Override sync set applies manual override at period start, else next cycle.
module motor_pwm_output_stage
	import pwm_out_pkg::*;
#(
	parameter int NUM_PAIRS = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] tb_count,
	input wire logic tb_period_start,
	input wire logic fault_in,
	output logic [2:0] high_side_output,
	output logic [2:0] low_side_output,
	output logic irq
);
	// ==========================================================
	// Implemented-bit masks
	localparam logic [5:0] PIN_MASK = 6'(( 1 << (2 * NUM_PAIRS)) - 1);
	localparam logic [2:0] PAIR_MASK = 3'((1 << NUM_PAIRS) - 1);

	logic [5:0] dt_sel_q;
	fault_ctl_s fault_ctl_q;
	logic [5:0] gen_ctrl_q;
	logic [5:0] manual_q;
	logic [5:0] gen_ctrl_act_q;
	logic [5:0] manual_act_q;
	logic [2:0][15:0] duty_buf_q;
	logic [2:0][15:0] duty_act_q;
	dt_cfg_s dt_cfg_q;
	pwm_ctl_s pwm_ctl_q;
	logic [INT_BITS-1:0] int_stat_q;
	logic [INT_BITS-1:0] int_mask_q;
	logic fault_prev_q;
	logic fault_latch_q;
	logic fault_cbc_q;
	logic [2:0] prescale_q;
	logic [31:0] rdata_d;
	logic addr_ok_d;
	logic wr_en;
	logic [15:0] wr16;
	logic fault_event;
	logic fault_active;
	logic tick_a;
	logic tick_b;

	// ==========================================================
	// APB slave: no wait state, read data captured in the setup cycle
	assign wr_en = psel & penable & pready & pwrite;

	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		merge16 = old_v;
		if (strb[0]) begin
			merge16[7:0] = new_v[7:0];
		end
		if (strb[1]) begin
			merge16[15:8] = new_v[15:8];
		end
	endfunction : merge16

	always_comb begin
		rdata_d = '0;
		addr_ok_d = 1'b1;
		case (paddr)
			DT_SEL_OFF: rdata_d[5:0] = dt_sel_q;
			FAULT_CTL_OFF: begin
				rdata_d[PIN_FIELD_LSB +: 6] = fault_ctl_q.ovr_val;
				rdata_d[FAULT_MODE_BIT] = fault_ctl_q.cycle_mode;
				rdata_d[2:0] = fault_ctl_q.pair_en;
			end
			OVD_CTL_OFF: begin
				rdata_d[PIN_FIELD_LSB +: 6] = gen_ctrl_q;
				rdata_d[5:0] = manual_q;
			end
			DUTY1_OFF: rdata_d[15:0] = duty_buf_q[0];
			DUTY2_OFF: rdata_d[15:0] = duty_buf_q[1];
			DUTY3_OFF: rdata_d[15:0] = duty_buf_q[2];
			DT_CFG_OFF: rdata_d[15:0] = dt_cfg_q;
			PWM_CTL_OFF: rdata_d[4:0] = pwm_ctl_q;
			INT_STAT_OFF: rdata_d[INT_BITS-1:0] = int_stat_q;
			INT_MASK_OFF: rdata_d[INT_BITS-1:0] = int_mask_q;
			default: addr_ok_d = 1'b0;
		endcase
	end

	// Strobed bytes merge into the current value; reserved bits enter as zero and are masked below
	assign wr16 = merge16(rdata_d[15:0], pwdata, pstrb);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata_d;
				pslverr <= ~addr_ok_d;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_sel_q <= '0;
			fault_ctl_q <= '0;
			gen_ctrl_q <= GEN_CTRL_RST & PIN_MASK;
			manual_q <= '0;
			duty_buf_q <= {3{DUTY_RST}};
			dt_cfg_q <= '0;
			pwm_ctl_q <= '0;
			int_mask_q <= '0;
		end else if (wr_en) begin
			case (paddr)
				DT_SEL_OFF: begin
					dt_sel_q <= wr16[5:0] & PIN_MASK;
				end
				FAULT_CTL_OFF: begin
					fault_ctl_q.ovr_val <= wr16[PIN_FIELD_LSB +: 6] & PIN_MASK;
					fault_ctl_q.cycle_mode <= wr16[FAULT_MODE_BIT];
					fault_ctl_q.pair_en <= wr16[2:0] & PAIR_MASK;
				end
				OVD_CTL_OFF: begin
					gen_ctrl_q <= wr16[PIN_FIELD_LSB +: 6] & PIN_MASK;
					manual_q <= wr16[5:0] & PIN_MASK;
				end
				DUTY1_OFF: duty_buf_q[0] <= wr16;
				DUTY2_OFF: duty_buf_q[1] <= wr16;
				DUTY3_OFF: duty_buf_q[2] <= wr16;
				DT_CFG_OFF: dt_cfg_q <= wr16;
				PWM_CTL_OFF: begin
					pwm_ctl_q <= wr16[4:0];
				end
				INT_MASK_OFF: int_mask_q <= pwdata[INT_BITS-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Active copies of duty and manual override
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_act_q <= {3{DUTY_RST}};
		end else if (pwm_ctl_q.immediate_duty_update | tb_period_start) begin
			duty_act_q <= duty_buf_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_ctrl_act_q <= GEN_CTRL_RST;
			manual_act_q <= '0;
		end else if (~pwm_ctl_q.override_sync_select | tb_period_start) begin
			// Synchronised mode avoids a shortened pulse when software flips a pin mid-period
			gen_ctrl_act_q <= gen_ctrl_q;
			manual_act_q <= manual_q;
		end
	end

	// ==========================================================
	// Fault handling
	assign fault_event = fault_in & ~fault_prev_q;
	assign fault_active = fault_ctl_q.cycle_mode ? fault_cbc_q : fault_latch_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_prev_q <= 1'b0;
			fault_latch_q <= 1'b0;
			fault_cbc_q <= 1'b0;
		end else begin
			fault_prev_q <= fault_in;
			// Latched fault holds until software clears the status bit with the input gone
			if (fault_in & ~fault_ctl_q.cycle_mode) begin
				fault_latch_q <= 1'b1;
			end else if (wr_en && paddr == INT_STAT_OFF && pwdata[INT_FAULT_BIT]) begin
				fault_latch_q <= 1'b0;
			end
			if (fault_in) begin
				fault_cbc_q <= 1'b1;
			end else if (tb_period_start) begin
				fault_cbc_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupt status, write one to clear, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			for (int i = 0; i < INT_BITS; i++) begin
				if ((i == INT_FAULT_BIT && fault_event) || (i == INT_PERIOD_BIT && tb_period_start)) begin
					int_stat_q[i] <= 1'b1;
				end else if (wr_en && paddr == INT_STAT_OFF && pwdata[i]) begin
					int_stat_q[i] <= 1'b0;
				end
			end
			irq <= |(int_stat_q & int_mask_q);
		end
	end

	// ==========================================================
	// Dead-time unit clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + 3'h1;
		end
	end

	function automatic logic unit_tick(input logic [1:0] ps, input logic [2:0] cnt);
		case (ps)
			DT_PS_DIV1: unit_tick = 1'b1;
			DT_PS_DIV2: unit_tick = (cnt[0] == 1'b0);
			DT_PS_DIV4: unit_tick = (cnt[1:0] == 2'h0);
			default: unit_tick = (cnt == 3'h0);
		endcase
	endfunction : unit_tick

	assign tick_a = unit_tick(dt_cfg_q.a_ps, prescale_q);
	assign tick_b = unit_tick(dt_cfg_q.b_ps, prescale_q);

	// ==========================================================
	// Per-pair generator, dead time and pin selection
	for (genvar p = 0; p < 3; p++) begin : g_pair
		if (p < NUM_PAIRS) begin : g_on
			dt_state_e state_q;
			logic raw_q;
			logic use_b_q;
			logic [5:0] dt_cnt_q;
			logic gen_h_q;
			logic gen_l_q;
			logic raw;
			logic dt_tick;
			logic pin_h;
			logic pin_l;

			assign raw = (tb_count < duty_act_q[p]);
			assign dt_tick = use_b_q ? tick_b : tick_a;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					state_q <= DT_IDLE;
					raw_q <= 1'b0;
					use_b_q <= 1'b0;
					dt_cnt_q <= '0;
					gen_h_q <= 1'b0;
					gen_l_q <= 1'b0;
				end else begin
					raw_q <= raw;
					case (state_q)
						DT_IDLE: begin
							if (pwm_ctl_q.indep_mode[p]) begin
								gen_h_q <= raw;
								gen_l_q <= raw;
							end else if (raw != raw_q) begin
								// Both switches off first so the phase leg never shoots through
								gen_h_q <= 1'b0;
								gen_l_q <= 1'b0;
								use_b_q <= raw ? dt_sel_q[2*p+1] : dt_sel_q[2*p];
								dt_cnt_q <= raw ? (dt_sel_q[2*p+1] ? dt_cfg_q.b_cnt : dt_cfg_q.a_cnt)
									: (dt_sel_q[2*p] ? dt_cfg_q.b_cnt : dt_cfg_q.a_cnt);
								state_q <= DT_WAIT;
							end else begin
								gen_h_q <= raw;
								gen_l_q <= ~raw;
							end
						end
						DT_WAIT: begin
							if (raw != raw_q) begin
								dt_cnt_q <= raw ? (dt_sel_q[2*p+1] ? dt_cfg_q.b_cnt : dt_cfg_q.a_cnt)
									: (dt_sel_q[2*p] ? dt_cfg_q.b_cnt : dt_cfg_q.a_cnt);
								use_b_q <= raw ? dt_sel_q[2*p+1] : dt_sel_q[2*p];
							end else if (dt_cnt_q == 6'h00) begin
								gen_h_q <= raw;
								gen_l_q <= ~raw;
								state_q <= DT_IDLE;
							end else if (dt_tick) begin
								dt_cnt_q <= dt_cnt_q - 6'h01;
							end
						end
						default: state_q <= DT_IDLE;
					endcase
				end
			end

			always_comb begin
				if (fault_active && fault_ctl_q.pair_en[p]) begin
					pin_h = fault_ctl_q.ovr_val[2*p+1];
					pin_l = fault_ctl_q.ovr_val[2*p];
				end else begin
					pin_h = gen_ctrl_act_q[2*p+1] ? gen_h_q : manual_act_q[2*p+1];
					pin_l = gen_ctrl_act_q[2*p] ? gen_l_q : manual_act_q[2*p];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					high_side_output[p] <= 1'b0;
					low_side_output[p] <= 1'b0;
				end else begin
					high_side_output[p] <= pin_h;
					low_side_output[p] <= pin_l;
				end
			end
		end else begin : g_off
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					high_side_output[p] <= 1'b0;
					low_side_output[p] <= 1'b0;
				end else begin
					high_side_output[p] <= 1'b0;
					low_side_output[p] <= 1'b0;
				end
			end
		end
	end
endmodule : motor_pwm_output_stage

// file: logic/pwm_out_pkg.sv
// Purpose: Shared constants and carriers for the motor PWM output stage.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Register fields are at most 16 bits wide, in the low half of each word.
package pwm_out_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] DT_SEL_OFF = 8'h00;
	localparam logic [7:0] FAULT_CTL_OFF = 8'h04;
	localparam logic [7:0] OVD_CTL_OFF = 8'h08;
	localparam logic [7:0] DUTY1_OFF = 8'h0C;
	localparam logic [7:0] DUTY2_OFF = 8'h10;
	localparam logic [7:0] DUTY3_OFF = 8'h14;
	localparam logic [7:0] DT_CFG_OFF = 8'h18;
	localparam logic [7:0] PWM_CTL_OFF = 8'h1C;
	localparam logic [7:0] INT_STAT_OFF = 8'h20;
	localparam logic [7:0] INT_MASK_OFF = 8'h24;

	// ==========================================================
	// Field positions and reset values
	localparam int PIN_FIELD_LSB = 8;
	localparam int FAULT_MODE_BIT = 7;
	localparam logic [5:0] GEN_CTRL_RST = 6'h3F;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam int INT_FAULT_BIT = 0;
	localparam int INT_PERIOD_BIT = 1;
	localparam int INT_BITS = 2;

	// ==========================================================
	// Dead-time prescale codes (unit clock = pclk divided by 1, 2, 4, 8)
	localparam logic [1:0] DT_PS_DIV1 = 2'h0;
	localparam logic [1:0] DT_PS_DIV2 = 2'h1;
	localparam logic [1:0] DT_PS_DIV4 = 2'h2;

	typedef struct packed {
		logic [1:0] b_ps;
		logic [5:0] b_cnt;
		logic [1:0] a_ps;
		logic [5:0] a_cnt;
	} dt_cfg_s;

	typedef struct packed {
		logic [5:0] ovr_val;
		logic cycle_mode;
		logic [2:0] pair_en;
	} fault_ctl_s;

	typedef struct packed {
		logic [2:0] indep_mode;
		logic immediate_duty_update;
		logic override_sync_select;
	} pwm_ctl_s;

	typedef enum logic [1:0] {
		DT_IDLE = 2'b01,
		DT_WAIT = 2'b10
	} dt_state_e;
endpackage : pwm_out_pkg

// file: tb/gate_drv_model.sv
// Purpose: Gate driver legs fed by the PWM pins.
// Assumes: One leg per pair, high and low switch.
// Notes: Counts cycles with both switches on while armed.
`timescale 1ns/10ps
module gate_drv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic arm,
	input wire logic [2:0] hi,
	input wire logic [2:0] lo,
	output logic [7:0] shoot_q
);
	// Both switches on shorts the rail; independent mode may do it on purpose, hence arm
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) shoot_q <= 8'h00;
		else if (arm && |(hi & lo)) shoot_q <= shoot_q + 8'h01;
	end
endmodule : gate_drv_model

// file: tb/motor_pwm_output_stage_bench.sv
// Purpose: Self-checking bench for the PWM output stage.
// Assumes: Time base count and period pulse driven by the bench.
// Notes: Reads are noted in a queue and compared as they complete.
`timescale 1ns/10ps
module motor_pwm_output_stage_bench;
	import pwm_out_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tps = 0, fault_in = 0, arm = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rnd = 32'hEE54;
	logic [15:0] tb_count = 16'h0000;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	logic [2:0] hi, lo;
	logic [7:0] shoot;
	logic [32:0] expq[$];
	int error_cnt = 0, checks_done = 0, cyc = 0;

	motor_pwm_output_stage u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tb_count(tb_count), .tb_period_start(tps), .fault_in(fault_in),
		.high_side_output(hi), .low_side_output(lo), .irq(irq));
	gate_drv_model u_drv (.pclk(pclk), .presetn(presetn), .arm(arm), .hi(hi), .lo(lo), .shoot_q(shoot));

	always #5 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report

	// ==========
	// Bus and pin helpers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Expected pattern is {high[2:0], low[2:0]}
	task automatic pins(input int n, input logic [5:0] e);
		repeat (n) @(posedge pclk);
		check({27'h0, hi, lo}, {27'h0, e}, "pins");
	endtask : pins

	task automatic tick();
		@(posedge pclk);
		tps <= 1'b1;
		@(posedge pclk);
		tps <= 1'b0;
	endtask : tick

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (expq.size() == 0) check(33'h0, 33'h1, "unexpected read");
			else check({pslverr, prdata}, expq.pop_front(), "read");
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(DT_SEL_OFF, 33'h0);
		rd(FAULT_CTL_OFF, 33'h0);
		rd(OVD_CTL_OFF, 33'h3F00);
		for (int i = 0; i < 3; i++) rd(DUTY1_OFF + 8'(4 * i), 33'h0);
		$display("test reset done");
		wr(DT_SEL_OFF, 32'hFFFFFFFF);
		rd(DT_SEL_OFF, 33'h3F);
		wr(FAULT_CTL_OFF, 32'hFFFF);
		rd(FAULT_CTL_OFF, 33'h3F87);
		wr(OVD_CTL_OFF, 32'hFFFF);
		rd(OVD_CTL_OFF, 33'h3F3F);
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			wr(DUTY1_OFF + 8'(4 * i), rnd);
			rd(DUTY1_OFF + 8'(4 * i), {17'h0, rnd[15:0]});
		end
		rd(8'h30, {1'b1, 32'h0});
		$display("test access done");
		wr(FAULT_CTL_OFF, 32'h0);
		wr(PWM_CTL_OFF, 32'h1C);
		wr(OVD_CTL_OFF, 32'h0029);
		pins(6, 6'b110001);
		wr(PWM_CTL_OFF, 32'h1D);
		wr(OVD_CTL_OFF, 32'h0000);
		pins(6, 6'b110001);
		tick();
		pins(6, 6'b000000);
		$display("test manual done");
		wr(PWM_CTL_OFF, 32'h1E);
		wr(OVD_CTL_OFF, 32'h3F00);
		wr(DUTY1_OFF, 32'hA);
		wr(DUTY2_OFF, 32'h0);
		wr(DUTY3_OFF, 32'hFFFF);
		tb_count <= 16'h9;
		pins(6, 6'b101101);
		tb_count <= 16'hA;
		pins(6, 6'b100100);
		wr(PWM_CTL_OFF, 32'h1C);
		wr(DUTY1_OFF, 32'hB);
		pins(6, 6'b100100);
		tick();
		pins(6, 6'b101101);
		$display("test generator done");
		wr(INT_MASK_OFF, 32'h1);
		wr(FAULT_CTL_OFF, 32'h0101);
		fault_in <= 1'b1;
		pins(6, 6'b100101);
		fault_in <= 1'b0;
		pins(6, 6'b100101);
		check({32'h0, irq}, 33'h1, "irq");
		wr(INT_MASK_OFF, 32'h0);
		pins(2, 6'b100101);
		check({32'h0, irq}, 33'h0, "irq masked");
		wr(INT_STAT_OFF, 32'h1);
		pins(6, 6'b101101);
		rd(INT_STAT_OFF, 33'h2);
		wr(FAULT_CTL_OFF, 32'h0181);
		fault_in <= 1'b1;
		pins(6, 6'b100101);
		fault_in <= 1'b0;
		pins(6, 6'b100101);
		tick();
		pins(6, 6'b101101);
		$display("test fault done");
		wr(FAULT_CTL_OFF, 32'h0);
		wr(DT_CFG_OFF, 32'h1402);
		wr(DT_SEL_OFF, 32'h02);
		wr(PWM_CTL_OFF, 32'h02);
		repeat (60) @(posedge pclk);
		arm <= 1'b1;
		tb_count <= 16'hB;
		pins(8, 6'b100011);
		tb_count <= 16'hA;
		pins(8, 6'b100010);
		pins(24, 6'b101010);
		check({25'h0, shoot}, 33'h0, "shoot through");
		$display("test dead time done");
		final_report();
	end
endmodule : motor_pwm_output_stage_bench

// file: tb/pwm_out_chk.sv
// Purpose: Port assertions for the PWM output stage register bus.
// Assumes: Zero-wait APB slave, answer in the first access cycle.
// Notes: Pin timing is judged by the bench.
`timescale 1ns/10ps
module pwm_out_chk
	import pwm_out_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic rd_v;
	assign rd_v = psel && penable && pready && !pwrite;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========
	// Bus timing and refusal
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_unmapped: assert property (psel && !penable && paddr > INT_MASK_OFF |=> pslverr)
		else $error("unmapped address not refused");
	a_err_mapped: assert property (psel && !penable && paddr <= INT_MASK_OFF && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped address refused");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h0)
		else $error("read data on a write");
	// ==========
	// Unimplemented bits read zero
	a_upper_zero: assert property (rd_v |-> prdata[31:16] == 16'h0)
		else $error("upper half not zero");
	a_dtsel_rsv: assert property (rd_v && paddr == DT_SEL_OFF |-> prdata[15:6] == 10'h0)
		else $error("edge select spare bits set");
	a_fault_rsv: assert property (rd_v && paddr == FAULT_CTL_OFF |-> prdata[15:14] == 2'h0 && prdata[6:3] == 4'h0)
		else $error("fault control spare bits set");
	a_ovd_rsv: assert property (rd_v && paddr == OVD_CTL_OFF |-> prdata[15:14] == 2'h0 && prdata[7:6] == 2'h0)
		else $error("override spare bits set");
endmodule : pwm_out_chk

bind motor_pwm_output_stage pwm_out_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
